// ===== rtl/nvs_i2c_slave.sv
module nvs_i2c_slave (
	// System clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Bus pins, sampled on the link clock
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_b_out,
	// Device select straps
	input wire logic [1:0] dev_sel_in,
	// Memory array port
	output logic [14:0] mem_addr_out,
	output logic mem_we_out,
	output logic mem_rd_out,
	input wire logic [7:0] mem_rdata_in,
	// Register file port
	output logic [7:0] reg_addr_out,
	output logic reg_we_out,
	output logic reg_rd_out,
	input wire logic [7:0] reg_rdata_in,
	// Write data for either port
	output logic [7:0] wr_data_out
);

	// ****************************************
	// Declarations
	// ****************************************
	nvs_pkg::nvs_sys_state_t state_reg;
	nvs_pkg::nvs_lnk_state_t lstate_reg;
	localparam logic [7:0] RSP_DATA_RESET_V = nvs_pkg::RSP_DATA_RESET;
	logic req_tgl_s, cond_tgl_s, rsp_tgl_s, lrst_b_s, scl_s, sda_s;
	logic [1:0] dev_sel_s;
	logic req_seen_reg, cond_seen_reg;
	logic req_evt, cond_evt, byte_evt, mack_evt;
	logic hit_mem, hit_reg, fetch_go, fetch_space, wr_go, acc_reg_space;
	logic [7:0] rx;
	logic reg_space_reg, drop_reg;
	logic [6:0] addr_hi_reg;
	logic [14:0] mem_ptr_reg;
	logic [7:0] reg_ptr_reg;
	logic rsp_tgl_reg, rsp_ack_reg, rsp_tx_reg;
	logic [7:0] rsp_data_reg;
	logic [14:0] mem_addr_reg;
	logic [7:0] reg_addr_reg, wr_data_reg;
	logic mem_we_reg, mem_rd_reg, reg_we_reg, reg_rd_reg;
	logic lnk_req_tgl_reg, lnk_cond_tgl_reg, lnk_kind_reg;
	logic [7:0] lnk_req_data_reg, rx_shift_reg, tx_shift_reg;
	logic [2:0] bit_cnt_reg;
	logic scl_d_reg, sda_d_reg, sda_oe_b_reg, sda_out_reg;
	logic pending, rise, fall, start, stop;

	// ****************************************
	// Crossings
	// ****************************************
	nvs_sync #(.WIDTH(4)) u_sys_sync (
		.clk_in(sys_clk_in),
		.d_in({lnk_req_tgl_reg, lnk_cond_tgl_reg, dev_sel_in}),
		.q_out({req_tgl_s, cond_tgl_s, dev_sel_s})
	);

	nvs_sync #(.WIDTH(4)) u_lnk_sync (
		.clk_in(link_clk_in),
		.d_in({scl_in, sda_in, rsp_tgl_reg, rst_b_in}),
		.q_out({scl_s, sda_s, rsp_tgl_s, lrst_b_s})
	);

	// ****************************************
	// System side: transaction decode
	// ****************************************
	// Link request words stay still until answered, so they are read directly
	assign rx = lnk_req_data_reg;
	assign req_evt = req_tgl_s != req_seen_reg;
	assign cond_evt = cond_tgl_s != cond_seen_reg;
	assign byte_evt = req_evt && lnk_kind_reg == nvs_pkg::REQ_BYTE;
	assign mack_evt = req_evt && lnk_kind_reg == nvs_pkg::REQ_MACK;
	assign hit_mem = rx[7:4] == nvs_pkg::MEM_TYPE_ID && rx[2:1] == dev_sel_s;
	assign hit_reg = rx[7:4] == nvs_pkg::REG_TYPE_ID && rx[2:1] == dev_sel_s;
	assign fetch_go = (byte_evt && state_reg == nvs_pkg::SYS_IDLE && (hit_mem || hit_reg) && rx[0])
		|| (mack_evt && state_reg == nvs_pkg::SYS_READ && !rx[0]);
	assign fetch_space = (state_reg == nvs_pkg::SYS_IDLE) ? hit_reg : reg_space_reg;
	assign wr_go = byte_evt && state_reg == nvs_pkg::SYS_WDATA;
	assign acc_reg_space = fetch_go ? fetch_space : reg_space_reg;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			req_seen_reg <= 1'b0;
			cond_seen_reg <= 1'b0;
		end else begin
			req_seen_reg <= req_tgl_s;
			cond_seen_reg <= cond_tgl_s;
		end
	end

	// ****************************************
	// System side: pointers
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			addr_hi_reg <= 7'h00;
			mem_ptr_reg <= nvs_pkg::MEM_PTR_RESET;
			reg_ptr_reg <= nvs_pkg::REG_PTR_RESET;
		end else if (byte_evt && state_reg == nvs_pkg::SYS_ADDR_HI) begin
			addr_hi_reg <= rx[6:0];
		end else if (byte_evt && state_reg == nvs_pkg::SYS_ADDR_LO) begin
			mem_ptr_reg <= {addr_hi_reg, rx};
		end else if (byte_evt && state_reg == nvs_pkg::SYS_REG_ADDR) begin
			if (rx <= nvs_pkg::REG_ADDR_LAST) begin
				reg_ptr_reg <= rx;
			end
		end else if (wr_go || fetch_go) begin
			// Step before the acknowledge slot; each space keeps its own pointer
			if (acc_reg_space) begin
				reg_ptr_reg <= reg_ptr_reg + 8'h01;
			end else if (mem_ptr_reg == nvs_pkg::MEM_ADDR_LAST) begin
				mem_ptr_reg <= nvs_pkg::MEM_PTR_RESET;
			end else begin
				mem_ptr_reg <= mem_ptr_reg + 15'h0001;
			end
		end
	end

	// ****************************************
	// System side: array and register ports
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			mem_we_reg <= 1'b0;
			mem_rd_reg <= 1'b0;
			reg_we_reg <= 1'b0;
			reg_rd_reg <= 1'b0;
			mem_addr_reg <= nvs_pkg::MEM_PTR_RESET;
			reg_addr_reg <= nvs_pkg::REG_PTR_RESET;
			wr_data_reg <= RSP_DATA_RESET_V;
		end else begin
			// Direct store, no page buffer: done long before the ack is driven
			mem_we_reg <= wr_go && !reg_space_reg;
			reg_we_reg <= wr_go && reg_space_reg;
			mem_rd_reg <= fetch_go && !fetch_space;
			reg_rd_reg <= fetch_go && fetch_space;
			if (wr_go || fetch_go) begin
				mem_addr_reg <= mem_ptr_reg;
				reg_addr_reg <= reg_ptr_reg;
				wr_data_reg <= rx;
			end
		end
	end

	// ****************************************
	// System side: transaction state and answers
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_reg <= nvs_pkg::SYS_IDLE;
			reg_space_reg <= 1'b0;
			drop_reg <= 1'b0;
			rsp_tgl_reg <= 1'b0;
			rsp_ack_reg <= 1'b0;
			rsp_tx_reg <= 1'b0;
			rsp_data_reg <= RSP_DATA_RESET_V;
		end else if (state_reg == nvs_pkg::SYS_FETCH) begin
			// Read data is answered one cycle after the port read
			rsp_data_reg <= reg_space_reg ? reg_rdata_in : mem_rdata_in;
			rsp_ack_reg <= 1'b1;
			rsp_tx_reg <= 1'b1;
			rsp_tgl_reg <= ~rsp_tgl_reg;
			drop_reg <= 1'b0;
			state_reg <= (drop_reg || cond_evt) ? nvs_pkg::SYS_IDLE : nvs_pkg::SYS_READ;
		end else if (req_evt) begin
			// Every request is answered exactly once; reads answer from the fetch
			rsp_tgl_reg <= rsp_tgl_reg ^ !fetch_go;
			rsp_ack_reg <= 1'b0;
			rsp_tx_reg <= 1'b0;
			case (state_reg)
				nvs_pkg::SYS_IDLE: begin
					if (byte_evt && (hit_mem || hit_reg)) begin
						reg_space_reg <= hit_reg;
						rsp_ack_reg <= 1'b1;
						if (rx[0]) begin
							state_reg <= nvs_pkg::SYS_FETCH;
						end else if (hit_reg) begin
							state_reg <= nvs_pkg::SYS_REG_ADDR;
						end else begin
							state_reg <= nvs_pkg::SYS_ADDR_HI;
						end
					end else begin
						state_reg <= nvs_pkg::SYS_IGNORE;
					end
				end
				nvs_pkg::SYS_ADDR_HI: begin
					rsp_ack_reg <= 1'b1;
					state_reg <= nvs_pkg::SYS_ADDR_LO;
				end
				nvs_pkg::SYS_ADDR_LO: begin
					rsp_ack_reg <= 1'b1;
					state_reg <= nvs_pkg::SYS_WDATA;
				end
				nvs_pkg::SYS_REG_ADDR: begin
					// Whole byte is compared, upper bits are not masked
					if (rx <= nvs_pkg::REG_ADDR_LAST) begin
						rsp_ack_reg <= 1'b1;
						state_reg <= nvs_pkg::SYS_WDATA;
					end else begin
						state_reg <= nvs_pkg::SYS_IGNORE;
					end
				end
				nvs_pkg::SYS_WDATA: begin
					rsp_ack_reg <= 1'b1;
				end
				nvs_pkg::SYS_READ: begin
					if (fetch_go) begin
						state_reg <= nvs_pkg::SYS_FETCH;
					end else begin
						state_reg <= nvs_pkg::SYS_IGNORE;
					end
				end
				default: begin
					state_reg <= nvs_pkg::SYS_IGNORE;
				end
			endcase
			if (cond_evt && fetch_go) begin
				drop_reg <= 1'b1;
			end else if (cond_evt) begin
				state_reg <= nvs_pkg::SYS_IDLE;
			end
		end else if (cond_evt) begin
			state_reg <= nvs_pkg::SYS_IDLE;
		end
	end

	assign mem_addr_out = mem_addr_reg;
	assign mem_we_out = mem_we_reg;
	assign mem_rd_out = mem_rd_reg;
	assign reg_addr_out = reg_addr_reg;
	assign reg_we_out = reg_we_reg;
	assign reg_rd_out = reg_rd_reg;
	assign wr_data_out = wr_data_reg;

	// ****************************************
	// Link side: bit engine
	// ****************************************
	assign pending = lnk_req_tgl_reg != rsp_tgl_s;
	assign rise = scl_s && !scl_d_reg;
	assign fall = !scl_s && scl_d_reg;
	assign start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	always_ff @(posedge link_clk_in) begin
		if (!lrst_b_s) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			sda_out_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			sda_out_reg <= 1'b0;
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!lrst_b_s) begin
			lstate_reg <= nvs_pkg::LNK_IDLE;
			bit_cnt_reg <= nvs_pkg::BIT_FIRST;
			sda_oe_b_reg <= 1'b1;
			lnk_req_tgl_reg <= 1'b0;
			lnk_cond_tgl_reg <= 1'b0;
			lnk_kind_reg <= nvs_pkg::REQ_BYTE;
			lnk_req_data_reg <= RSP_DATA_RESET_V;
			rx_shift_reg <= RSP_DATA_RESET_V;
			tx_shift_reg <= RSP_DATA_RESET_V;
		end else if (start || stop) begin
			// A partial byte is dropped here, so memory stays untouched
			lstate_reg <= start ? nvs_pkg::LNK_RX : nvs_pkg::LNK_IDLE;
			bit_cnt_reg <= nvs_pkg::BIT_FIRST;
			sda_oe_b_reg <= 1'b1;
			lnk_cond_tgl_reg <= ~lnk_cond_tgl_reg;
		end else begin
			case (lstate_reg)
				nvs_pkg::LNK_RX: begin
					if (rise) begin
						rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == nvs_pkg::BIT_LAST) begin
							lnk_req_data_reg <= {rx_shift_reg[6:0], sda_s};
							lnk_kind_reg <= nvs_pkg::REQ_BYTE;
							lnk_req_tgl_reg <= ~lnk_req_tgl_reg;
							lstate_reg <= nvs_pkg::LNK_WAIT;
						end
					end
				end
				nvs_pkg::LNK_WAIT: begin
					// Hold off the ack until the answer is back and SCL is low
					if (!pending && !scl_s) begin
						sda_oe_b_reg <= !rsp_ack_reg;
						lstate_reg <= rsp_ack_reg ? nvs_pkg::LNK_ACK : nvs_pkg::LNK_IDLE;
					end
				end
				nvs_pkg::LNK_ACK: begin
					if (fall) begin
						bit_cnt_reg <= nvs_pkg::BIT_FIRST;
						tx_shift_reg <= rsp_data_reg;
						sda_oe_b_reg <= rsp_tx_reg ? rsp_data_reg[7] : 1'b1;
						lstate_reg <= rsp_tx_reg ? nvs_pkg::LNK_TX : nvs_pkg::LNK_RX;
					end
				end
				nvs_pkg::LNK_TX: begin
					if (fall && bit_cnt_reg == nvs_pkg::BIT_LAST) begin
						sda_oe_b_reg <= 1'b1;
						lstate_reg <= nvs_pkg::LNK_MACK;
					end else if (fall) begin
						tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
						sda_oe_b_reg <= tx_shift_reg[6];
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
				end
				nvs_pkg::LNK_MACK: begin
					if (rise) begin
						lnk_req_data_reg <= {7'h00, sda_s};
						lnk_kind_reg <= nvs_pkg::REQ_MACK;
						lnk_req_tgl_reg <= ~lnk_req_tgl_reg;
						lstate_reg <= sda_s ? nvs_pkg::LNK_IDLE : nvs_pkg::LNK_NEXT;
					end
				end
				nvs_pkg::LNK_NEXT: begin
					if (!pending && !scl_s) begin
						bit_cnt_reg <= nvs_pkg::BIT_FIRST;
						tx_shift_reg <= rsp_data_reg;
						sda_oe_b_reg <= rsp_tx_reg ? rsp_data_reg[7] : 1'b1;
						lstate_reg <= rsp_tx_reg ? nvs_pkg::LNK_TX : nvs_pkg::LNK_IDLE;
					end
				end
				default: begin
					lstate_reg <= nvs_pkg::LNK_IDLE;
				end
			endcase
		end
	end

	assign sda_out = sda_out_reg;
	assign sda_oe_b_out = sda_oe_b_reg;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_mem_read_addr;
		byte_evt && state_reg == nvs_pkg::SYS_IDLE && hit_mem && rx[0];
	endsequence

	sequence s_port_read;
		mem_rd_out && state_reg == nvs_pkg::SYS_FETCH;
	endsequence

	sequence s_mem_write;
		wr_go && !reg_space_reg;
	endsequence

	read_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_mem_read_addr |=> s_port_read ##1 (rsp_tx_reg && rsp_ack_reg))
		else $error("read address did not start a fetch");
	read_from_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_mem_read_addr |=> mem_addr_out == $past(mem_ptr_reg))
		else $error("read did not use the latched address");
	write_commit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_mem_write |=> mem_we_out && wr_data_out == $past(rx) && rsp_ack_reg)
		else $error("written byte not stored and acknowledged");
	wrap_top_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_mem_write and (mem_ptr_reg == nvs_pkg::MEM_ADDR_LAST)
		|=> mem_ptr_reg == nvs_pkg::MEM_PTR_RESET)
		else $error("memory pointer did not wrap");
	seq_next_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(fetch_go && state_reg == nvs_pkg::SYS_READ && !reg_space_reg
		&& mem_ptr_reg != nvs_pkg::MEM_ADDR_LAST)
		|=> mem_rd_out && mem_ptr_reg == $past(mem_ptr_reg) + 15'h0001)
		else $error("sequential read did not advance");
	reg_range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		byte_evt && state_reg == nvs_pkg::SYS_REG_ADDR && rx > nvs_pkg::REG_ADDR_LAST
		|=> state_reg == nvs_pkg::SYS_IGNORE && !rsp_ack_reg)
		else $error("illegal register address acknowledged");
	mem_ptr_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		reg_space_reg && (state_reg == nvs_pkg::SYS_WDATA || state_reg == nvs_pkg::SYS_READ)
		|=> $stable(mem_ptr_reg))
		else $error("register access moved the memory pointer");
	read_nack_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		mack_evt && state_reg == nvs_pkg::SYS_READ && rx[0]
		|=> state_reg == nvs_pkg::SYS_IGNORE && !mem_rd_out)
		else $error("read continued after master nack");
	release_a: assert property (@(posedge link_clk_in) disable iff (!lrst_b_s)
		lstate_reg == nvs_pkg::LNK_MACK && rise && sda_s && !start && !stop
		|=> sda_oe_b_out [*2])
		else $error("bus not released after master nack");

endmodule

// ===== rtl/nvs_pkg.sv
package nvs_pkg;

	// ****************************************
	// Addressing
	// ****************************************
	localparam logic [3:0] MEM_TYPE_ID = 4'ha;
	localparam logic [3:0] REG_TYPE_ID = 4'hd;
	localparam logic [7:0] REG_ADDR_LAST = 8'h18;
	localparam logic [14:0] MEM_ADDR_LAST = 15'h7fff;
	localparam logic [14:0] MEM_PTR_RESET = 15'h0000;
	localparam logic [7:0] REG_PTR_RESET = 8'h00;
	localparam logic [7:0] RSP_DATA_RESET = 8'h00;

	// ****************************************
	// Link framing
	// ****************************************
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic REQ_BYTE = 1'b0;
	localparam logic REQ_MACK = 1'b1;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [2:0] {
		SYS_IDLE, SYS_ADDR_HI, SYS_ADDR_LO, SYS_REG_ADDR,
		SYS_WDATA, SYS_FETCH, SYS_READ, SYS_IGNORE
	} nvs_sys_state_t;

	typedef enum logic [2:0] {
		LNK_IDLE, LNK_RX, LNK_WAIT, LNK_ACK, LNK_NEXT, LNK_TX, LNK_MACK
	} nvs_lnk_state_t;

endpackage

// ===== rtl/nvs_sync.sv
module nvs_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock
	input wire logic clk_in,
	// Asynchronous levels in, filtered levels out
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge clk_in) begin
		s1_reg <= d_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// A change is taken only once two later stages agree
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				q_reg[i] <= s3_reg[i];
			end
		end
	end

	assign q_out = q_reg;

endmodule

// ===== verification/nvs_i2c_master.sv
module nvs_i2c_master (
	// Bus lines
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Half bus period, long enough for the crossing round trip
	localparam int HALF = 4000;

	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// Works from idle and as a repeated start after a byte
	task automatic start_cond();
		#(HALF/2) sda_low_out = 1'b0;
		#(HALF/2) scl_out = 1'b1;
		#HALF sda_low_out = 1'b1;
		#HALF scl_out = 1'b0;
	endtask

	task automatic stop_cond();
		#(HALF/2) sda_low_out = 1'b1;
		#(HALF/2) scl_out = 1'b1;
		#HALF sda_low_out = 1'b0;
		#HALF;
	endtask

	task automatic put_bit(input logic b);
		#(HALF/2) sda_low_out = ~b;
		#(HALF/2) scl_out = 1'b1;
		#HALF scl_out = 1'b0;
	endtask

	// Releases the line so the pull-up shows when nobody drives it
	task automatic get_bit(output logic b);
		#(HALF/2) sda_low_out = 1'b0;
		#(HALF/2) scl_out = 1'b1;
		#(HALF/2) b = sda_in;
		#(HALF/2) scl_out = 1'b0;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic nak;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(nak);
		ack = ~nak;
	endtask

	// A no-acknowledge ends the read; the caller then issues STOP or START
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic b;
		for (int i = 0; i < 8; i++) begin
			get_bit(b);
			d = {d[6:0], b};
		end
		put_bit(~ack);
	endtask
endmodule

// ===== verification/nvs_i2c_slave_bench.sv
module nvs_i2c_slave_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Clocks, pins and array models
	// ****************************************
	localparam logic [1:0] SEL = 2'h1;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] dev_sel = SEL;
	logic scl, m_low, sda_out, sda_oe_b, sda;
	logic [14:0] mem_addr;
	logic [7:0] reg_addr, wr_data;
	logic mem_we, reg_we, mem_rd, reg_rd;
	logic [7:0] mem [0:32767];
	logic [7:0] regs [0:255];
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int mem_rds = 0;
	int reg_rds = 0;

	always #50 sys_clk = ~sys_clk;
	initial #37 forever #80 link_clk = ~link_clk;

	// Open-drain wire with pull-up
	assign sda = (~sda_oe_b ? sda_out : 1'b1) & ~m_low;

	always @(posedge sys_clk) begin
		if (mem_we) mem[mem_addr] <= wr_data;
		if (reg_we) regs[reg_addr] <= wr_data;
		// Each fetch strobe is one byte taken from the array or the register file
		if (mem_rd) mem_rds++;
		if (reg_rd) reg_rds++;
	end

	nvs_i2c_master m (
		.scl_out(scl),
		.sda_low_out(m_low),
		.sda_in(sda)
	);

	nvs_i2c_slave dut (
		.sys_clk_in(sys_clk),
		.rst_b_in(rst_b),
		.link_clk_in(link_clk),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe_b_out(sda_oe_b),
		.dev_sel_in(dev_sel),
		.mem_addr_out(mem_addr),
		.mem_we_out(mem_we),
		.mem_rd_out(mem_rd),
		.mem_rdata_in(mem[mem_addr]),
		.reg_addr_out(reg_addr),
		.reg_we_out(reg_we),
		.reg_rd_out(reg_rd),
		.reg_rdata_in(regs[reg_addr]),
		.wr_data_out(wr_data)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] d, input logic exp_ack);
		logic a;
		m.wbyte(d, a);
		check({7'h0, a}, {7'h0, exp_ack});
	endtask

	task automatic rd(input logic ack, input logic [7:0] exp);
		logic [7:0] d;
		m.rbyte(ack, d);
		check(d, exp);
	endtask

	function automatic logic [7:0] sa(input logic [3:0] t, input logic rw);
		return {t, 1'b0, SEL, rw};
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_write_wrap();
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b0), 1'b1);
		wr(8'h7f, 1'b1);
		wr(8'hfe, 1'b1);
		wr(8'h5a, 1'b1);
		wr(8'h6b, 1'b1);
		wr(8'h7c, 1'b1);
		m.stop_cond();
		check(mem[15'h7ffe], 8'h5a);
		check(mem[15'h7fff], 8'h6b);
		check(mem[15'h0000], 8'h7c);
		// Polling right after the write must find the device ready
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b0), 1'b1);
		m.stop_cond();
		$display("test write_wrap done");
	endtask

	task automatic t_abort();
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b0), 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h10, 1'b1);
		wr(8'h55, 1'b1);
		repeat (4) m.put_bit(1'b1);
		m.stop_cond();
		check(mem[15'h0010], 8'h55);
		check(mem[15'h0011], 8'h11);
		$display("test abort done");
	endtask

	task automatic t_read_wrap();
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b0), 1'b1);
		wr(8'h7f, 1'b1);
		wr(8'hff, 1'b1);
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b1), 1'b1);
		rd(1'b1, 8'h6b);
		rd(1'b0, 8'h7c);
		m.stop_cond();
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b1), 1'b1);
		rd(1'b0, 8'h01);
		m.stop_cond();
		check(8'(mem_rds), 8'h03);
		$display("test read_wrap done");
	endtask

	task automatic t_regs();
		m.start_cond();
		wr(sa(nvs_pkg::REG_TYPE_ID, 1'b0), 1'b1);
		wr(8'h05, 1'b1);
		wr(8'h3c, 1'b1);
		wr(8'h3d, 1'b1);
		m.stop_cond();
		check(regs[5], 8'h3c);
		check(regs[6], 8'h3d);
		m.start_cond();
		wr(sa(nvs_pkg::REG_TYPE_ID, 1'b0), 1'b1);
		wr(8'h19, 1'b0);
		m.stop_cond();
		m.start_cond();
		wr(sa(nvs_pkg::REG_TYPE_ID, 1'b0), 1'b1);
		wr(8'h18, 1'b1);
		m.start_cond();
		wr(sa(nvs_pkg::REG_TYPE_ID, 1'b1), 1'b1);
		rd(1'b1, 8'he7);
		rd(1'b0, 8'he6);
		m.stop_cond();
		check(8'(reg_rds), 8'h02);
		// Memory pointer still sits where the earlier read left it
		m.start_cond();
		wr(sa(nvs_pkg::MEM_TYPE_ID, 1'b1), 1'b1);
		rd(1'b0, 8'h02);
		m.stop_cond();
		check(8'(mem_rds), 8'h04);
		$display("test regs done");
	endtask

	task automatic t_select();
		m.start_cond();
		wr({nvs_pkg::MEM_TYPE_ID, 1'b0, ~SEL, 1'b0}, 1'b0);
		m.stop_cond();
		m.start_cond();
		wr(sa(4'h0, 1'b0), 1'b0);
		m.stop_cond();
		$display("test select done");
	endtask

	// ****************************************
	// Main sequence and hang guard
	// ****************************************
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = 8'(i) ^ {1'b0, 7'(i >> 8)};
		end
		for (int i = 0; i < 256; i++) begin
			regs[i] = ~8'(i);
		end
		// Long enough for the link-domain reset synchroniser
		repeat (12) @(negedge link_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		repeat (10) @(posedge link_clk);
		t_write_wrap();
		t_abort();
		t_read_wrap();
		t_regs();
		t_select();
		close_out();
	end
endmodule
